/* design/cla_limit_ao.sv */
`timescale 1ns/1ps
`default_nettype none

module cla_limit_ao #(
	parameter int TICK_CYC = cla_pkg::TICK_CYC
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_stb_i,
	input wire logic wb_cyc_i,
	output logic wb_ack_o,
	// Loop side
	input wire logic signed [31:0] ctrl_temp_i,
	input wire logic signed [1:0][15:0] pid_i,
	input wire logic signed [1:0][31:0] reading_i,
	output logic signed [31:0] setpoint_o,
	output logic overtemp_o,
	output logic signed [1:0][15:0] ctrl_o,
	output logic [2:0] heater_range_o,
	// DAC codes, 1.25 mV per step
	output logic signed [1:0][14:0] dac_o
);

	// ****************************************
	// State
	// ****************************************
	logic signed [31:0] glim_q, glim_d, clim_q, clim_d, sp_q, sp_d;
	logic curve_en_q, curve_en_d;
	cla_pkg::cla_units_t units_q, units_d;
	logic [1:0] loop_en_q, loop_en_d;
	cla_pkg::cla_slope_t slope_q, slope_d;
	logic [2:0] range_q, range_d, rlim_q, rlim_d;
	logic refused_q, refused_d, clamped_q, clamped_d;
	cla_pkg::cla_ao_set_t [1:0] ao_q, ao_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic signed [1:0][15:0] out_q, out_d;
	logic signed [1:0][14:0] dac_q, dac_d;

	logic [7:0] adr;
	logic take, wr;
	logic signed [31:0] eff_lim;
	logic tick, over;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	assign adr = {wb_adr_i[7:2], 2'b00};
	// One wait state: taken here, ack next cycle, then dropped
	assign take = wb_cyc_i && wb_stb_i && !ack_q && ce_i;
	assign wr = take && wb_we_i;

	// ****************************************
	// Limits
	// ****************************************
	always_comb begin
		eff_lim = glim_q;
		if (curve_en_q && clim_q < glim_q) begin
			eff_lim = clim_q;
		end
	end

	assign over = ctrl_temp_i > glim_q;
	assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));

	// ****************************************
	// Register writes and bus answer
	// ****************************************
	always_comb begin
		logic [31:0] m;
		logic signed [31:0] req_k;
		m = '0;
		req_k = '0;
		glim_d = glim_q;
		clim_d = clim_q;
		curve_en_d = curve_en_q;
		sp_d = sp_q;
		units_d = units_q;
		loop_en_d = loop_en_q;
		slope_d = slope_q;
		range_d = range_q;
		rlim_d = rlim_q;
		refused_d = refused_q;
		clamped_d = clamped_q;
		ao_d = ao_q;
		ack_d = take;
		rdat_d = rdat_q;
		if (wr) begin
			unique case (adr)
				cla_pkg::A_GLIM: glim_d = merge(glim_q, wb_dat_i, wb_sel_i);
				cla_pkg::A_CLIM: begin
					m = merge({curve_en_q, clim_q[30:0]}, wb_dat_i, wb_sel_i);
					curve_en_d = m[cla_pkg::CLIM_EN_BIT];
					clim_d = {1'b0, m[30:0]};
				end
				cla_pkg::A_SP: begin
					m = merge(sp_q, wb_dat_i, wb_sel_i);
					req_k = (units_q == cla_pkg::UNIT_C) ? m + cla_pkg::C_TO_K : m;
					sp_d = m;
					clamped_d = 1'b0;
					// Sensor units have no kelvin meaning, so no limit
					if (units_q != cla_pkg::UNIT_SENSOR && req_k > eff_lim) begin
						sp_d = (units_q == cla_pkg::UNIT_C) ? eff_lim - cla_pkg::C_TO_K
							: eff_lim;
						clamped_d = 1'b1;
					end
				end
				cla_pkg::A_CTRL: begin
					m = merge({28'h0, loop_en_q, units_q}, wb_dat_i, wb_sel_i);
					units_d = cla_pkg::cla_units_t'(m[cla_pkg::CTRL_UNITS_LSB +: 2]);
					loop_en_d = m[cla_pkg::CTRL_EN_LSB +: 2];
				end
				cla_pkg::A_SLOPE: begin
					m = merge({6'h0, slope_q.fall, 6'h0, slope_q.rise}, wb_dat_i, wb_sel_i);
					if (m[9:0] <= cla_pkg::SLOPE_MAX) begin
						slope_d.rise = m[9:0];
					end
					if (m[cla_pkg::SLOPE_FALL_LSB +: 10] <= cla_pkg::SLOPE_MAX) begin
						slope_d.fall = m[cla_pkg::SLOPE_FALL_LSB +: 10];
					end
				end
				cla_pkg::A_HTR: begin
					m = merge({21'h0, rlim_q, 5'h0, range_q}, wb_dat_i, wb_sel_i);
					if (m[cla_pkg::HTR_LIM_LSB +: 3] <= cla_pkg::RANGE_MAX) begin
						rlim_d = m[cla_pkg::HTR_LIM_LSB +: 3];
					end
					// Loop 1 heater only; loop 2 has no range
					if (m[2:0] <= rlim_d) begin
						range_d = m[2:0];
						refused_d = 1'b0;
					end else begin
						refused_d = 1'b1;
					end
				end
				default: begin
					for (int c = 0; c < 2; c++) begin
						if (adr == 8'(cla_pkg::A_AO_BASE + c * cla_pkg::A_AO_STRIDE
							+ cla_pkg::A_AO_CFG)) begin
							m = merge({29'h0, ao_q[c].bipolar, ao_q[c].mode}, wb_dat_i, wb_sel_i);
							ao_d[c].bipolar = m[cla_pkg::AO_BIP_BIT];
							if (c == 1 || m[1:0] != cla_pkg::AO_LOOP) begin
								ao_d[c].mode = cla_pkg::cla_ao_mode_t'(m[1:0]);
							end
						end
						if (adr == 8'(cla_pkg::A_AO_BASE + c * cla_pkg::A_AO_STRIDE
							+ cla_pkg::A_AO_MAN)) begin
							ao_d[c].man = merge(ao_q[c].man, wb_dat_i, wb_sel_i);
						end
						if (adr == 8'(cla_pkg::A_AO_BASE + c * cla_pkg::A_AO_STRIDE
							+ cla_pkg::A_AO_LOW)) begin
							ao_d[c].low = merge(ao_q[c].low, wb_dat_i, wb_sel_i);
						end
						if (adr == 8'(cla_pkg::A_AO_BASE + c * cla_pkg::A_AO_STRIDE
							+ cla_pkg::A_AO_HIGH)) begin
							ao_d[c].high = merge(ao_q[c].high, wb_dat_i, wb_sel_i);
						end
					end
				end
			endcase
		end
		if (take) begin
			rdat_d = 32'h0;
			unique case (adr)
				cla_pkg::A_GLIM: rdat_d = glim_q;
				cla_pkg::A_CLIM: rdat_d = {curve_en_q, clim_q[30:0]};
				cla_pkg::A_SP: rdat_d = sp_q;
				cla_pkg::A_CTRL: rdat_d = {28'h0, loop_en_q, units_q};
				cla_pkg::A_STAT: rdat_d = {29'h0, clamped_q, refused_q, over};
				cla_pkg::A_SLOPE: rdat_d = {6'h0, slope_q.fall, 6'h0, slope_q.rise};
				cla_pkg::A_HTR: rdat_d = {21'h0, rlim_q, 5'h0, range_q};
				default: begin
					for (int c = 0; c < 2; c++) begin
						if (adr == 8'(cla_pkg::A_AO_BASE + c * cla_pkg::A_AO_STRIDE
							+ cla_pkg::A_AO_CFG)) begin
							rdat_d = {29'h0, ao_q[c].bipolar, ao_q[c].mode};
						end
						if (adr == 8'(cla_pkg::A_AO_BASE + c * cla_pkg::A_AO_STRIDE
							+ cla_pkg::A_AO_MAN)) begin
							rdat_d = ao_q[c].man;
						end
						if (adr == 8'(cla_pkg::A_AO_BASE + c * cla_pkg::A_AO_STRIDE
							+ cla_pkg::A_AO_LOW)) begin
							rdat_d = ao_q[c].low;
						end
						if (adr == 8'(cla_pkg::A_AO_BASE + c * cla_pkg::A_AO_STRIDE
							+ cla_pkg::A_AO_HIGH)) begin
							rdat_d = ao_q[c].high;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			glim_q <= cla_pkg::GLIM_RST;
			clim_q <= cla_pkg::CLIM_RST;
			curve_en_q <= 1'b0;
			sp_q <= 32'h0;
			units_q <= cla_pkg::UNIT_K;
			loop_en_q <= 2'h0;
			slope_q <= '{rise: cla_pkg::SLOPE_RST, fall: cla_pkg::SLOPE_RST};
			range_q <= cla_pkg::RANGE_RST;
			rlim_q <= cla_pkg::RANGE_MAX;
			refused_q <= 1'b0;
			clamped_q <= 1'b0;
			for (int c = 0; c < 2; c++) begin
				ao_q[c] <= '{mode: cla_pkg::AO_OFF, bipolar: 1'b0, man: 32'h0,
					low: cla_pkg::AO_LOW_RST, high: cla_pkg::AO_HIGH_RST};
			end
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end else if (ce_i) begin
			glim_q <= glim_d;
			clim_q <= clim_d;
			curve_en_q <= curve_en_d;
			sp_q <= sp_d;
			units_q <= units_d;
			loop_en_q <= loop_en_d;
			slope_q <= slope_d;
			range_q <= range_d;
			rlim_q <= rlim_d;
			refused_q <= refused_d;
			clamped_q <= clamped_d;
			ao_q <= ao_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// ****************************************
	// Slope limited control outputs
	// ****************************************
	always_comb begin
		logic signed [16:0] diff;
		logic signed [16:0] step_up, step_dn;
		diff = '0;
		// Step is rate in 0.1 %/s scaled to 0.01 % per tick
		step_up = 17'((32'(slope_q.rise) * cla_pkg::TICK_MS) / 100);
		step_dn = 17'((32'(slope_q.fall) * cla_pkg::TICK_MS) / 100);
		tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
		out_d = out_q;
		for (int l = 0; l < 2; l++) begin
			diff = 17'($signed(pid_i[l])) - 17'($signed(out_q[l]));
			// Shutoff bypasses the slope so it is immediate
			if (!loop_en_q[l] || over) begin
				out_d[l] = 16'h0;
			end else if (tick) begin
				if (diff > 0) begin
					out_d[l] = (slope_q.rise == 10'h0 || diff <= step_up) ? pid_i[l]
						: 16'(out_q[l] + step_up);
				end else if (diff < 0) begin
					out_d[l] = (slope_q.fall == 10'h0 || -diff <= step_dn) ? pid_i[l]
						: 16'(out_q[l] - step_dn);
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_q <= 32'h0;
			out_q <= '0;
		end else if (ce_i) begin
			tick_cnt_q <= tick_cnt_d;
			out_q <= out_d;
		end
	end

	// ****************************************
	// Analog output channels
	// ****************************************
	for (genvar c = 0; c < 2; c++) begin : g_ao
		logic signed [47:0] num, span, q;
		logic signed [31:0] pct;
		logic signed [14:0] lo, raw;

		always_comb begin
			lo = ao_q[c].bipolar ? -cla_pkg::CODE_FS : 15'h0;
			num = 48'($signed(reading_i[c])) - 48'($signed(ao_q[c].low));
			span = 48'($signed(ao_q[c].high)) - 48'($signed(ao_q[c].low));
			q = 48'h0;
			pct = 32'h0;
			raw = 15'h0;
			unique case (ao_q[c].mode)
				cla_pkg::AO_OFF: raw = 15'h0;
				cla_pkg::AO_INPUT: begin
					// Saturate outside low..high so the divide never overflows
					if (span <= 0 || num <= 0) begin
						raw = lo;
					end else if (num >= span) begin
						raw = cla_pkg::CODE_FS;
					end else begin
						q = (num * 48'(cla_pkg::CODE_FS - lo)) / span;
						raw = 15'(q) + lo;
					end
				end
				cla_pkg::AO_LOOP: pct = 32'($signed(out_q[1]));
				cla_pkg::AO_MANUAL: pct = $signed(ao_q[c].man);
			endcase
			if (ao_q[c].mode == cla_pkg::AO_LOOP || ao_q[c].mode == cla_pkg::AO_MANUAL) begin
				if (pct >= 32'(cla_pkg::PCT_FS)) begin
					raw = cla_pkg::CODE_FS;
				end else if (pct <= -32'(cla_pkg::PCT_FS)) begin
					raw = -cla_pkg::CODE_FS;
				end else begin
					raw = 15'((pct * 32'(cla_pkg::CODE_FS)) / 32'(cla_pkg::PCT_FS));
				end
			end
			dac_d[c] = (raw < lo) ? lo : raw;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dac_q <= '0;
		end else if (ce_i) begin
			dac_q <= dac_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign setpoint_o = sp_q;
	assign overtemp_o = over;
	assign ctrl_o = out_q;
	assign heater_range_o = range_q;
	assign dac_o = dac_q;

endmodule

`default_nettype wire

/* design/cla_pkg.sv */
package cla_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 100;
	localparam int TICK_MS = 100;
	localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] A_GLIM = 8'h00;
	localparam logic [7:0] A_CLIM = 8'h04;
	localparam logic [7:0] A_SP = 8'h08;
	localparam logic [7:0] A_CTRL = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_SLOPE = 8'h14;
	localparam logic [7:0] A_HTR = 8'h18;
	localparam logic [7:0] A_AO_BASE = 8'h20;
	localparam logic [7:0] A_AO_STRIDE = 8'h10;
	localparam logic [7:0] A_AO_CFG = 8'h00;
	localparam logic [7:0] A_AO_MAN = 8'h04;
	localparam logic [7:0] A_AO_LOW = 8'h08;
	localparam logic [7:0] A_AO_HIGH = 8'h0C;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_UNITS_LSB = 0;
	localparam int CTRL_EN_LSB = 2;
	localparam int CLIM_EN_BIT = 31;
	localparam int SLOPE_FALL_LSB = 16;
	localparam int HTR_LIM_LSB = 8;
	localparam int AO_BIP_BIT = 2;

	// ****************************************
	// Values after reset and scale limits
	// ****************************************
	// Temperatures in 0.01 K, output in 0.01 %, DAC code in 1.25 mV
	localparam logic signed [31:0] GLIM_RST = 32'h0000B98C;
	localparam logic signed [31:0] CLIM_RST = 32'h0000B98C;
	localparam logic signed [31:0] C_TO_K = 32'h00006AB3;
	localparam logic [9:0] SLOPE_RST = 10'h000;
	localparam logic [9:0] SLOPE_MAX = 10'h3E8;
	localparam logic [2:0] RANGE_RST = 3'h0;
	localparam logic [2:0] RANGE_MAX = 3'h5;
	localparam logic signed [15:0] PCT_FS = 16'h2710;
	localparam logic signed [14:0] CODE_FS = 15'h1F40;
	localparam logic signed [31:0] AO_LOW_RST = 32'h00000000;
	localparam logic signed [31:0] AO_HIGH_RST = 32'h000003E8;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {UNIT_K, UNIT_C, UNIT_SENSOR, UNIT_RSVD} cla_units_t;
	typedef enum logic [1:0] {AO_OFF, AO_INPUT, AO_LOOP, AO_MANUAL} cla_ao_mode_t;

	typedef struct packed {
		cla_ao_mode_t mode;
		logic bipolar;
		logic signed [31:0] man;
		logic signed [31:0] low;
		logic signed [31:0] high;
	} cla_ao_set_t;

	typedef struct packed {
		logic [9:0] rise;
		logic [9:0] fall;
	} cla_slope_t;

endpackage

/* dv/cla_limit_ao_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cla_limit_ao_asserts #(
	parameter int TICK_CYC = cla_pkg::TICK_CYC
) (
	// Clock and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_stb_i,
	input wire logic wb_cyc_i,
	input wire logic wb_ack_o,
	// Loop side
	input wire logic signed [31:0] ctrl_temp_i,
	input wire logic signed [1:0][15:0] pid_i,
	input wire logic signed [1:0][31:0] reading_i,
	input wire logic signed [31:0] setpoint_o,
	input wire logic overtemp_o,
	input wire logic signed [1:0][15:0] ctrl_o,
	input wire logic [2:0] heater_range_o,
	input wire logic signed [1:0][14:0] dac_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire take_w = wb_cyc_i & wb_stb_i & ce_i & ~wb_ack_o;
	wire sp_wr_w = take_w & wb_we_i & (wb_adr_i[7:2] == cla_pkg::A_SP[7:2]);
	wire htr_wr_w = take_w & wb_we_i & (wb_adr_i[7:2] == cla_pkg::A_HTR[7:2]);
	// ****************
	// Bus handshake
	// ****************
	sequence s_take; take_w; endsequence
	sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack_answer; s_take |=> s_pulse; endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("ack late or long");
	property p_ack_cause; wb_ack_o |-> $past(take_w); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	// ****************
	// Limits and outputs
	// ****************
	property p_sp_hold; !$stable(setpoint_o) |-> $past(sp_wr_w) || $past(sp_wr_w, 2); endproperty
	a_sp_hold: assert property (p_sp_hold) else $error("setpoint moved alone");
	property p_overtemp_off; overtemp_o && ce_i |=> ctrl_o == '0; endproperty
	a_overtemp_off: assert property (p_overtemp_off) else $error("output on in overtemp");
	property p_range_cap; heater_range_o <= cla_pkg::RANGE_MAX; endproperty
	a_range_cap: assert property (p_range_cap) else $error("range above top");
	property p_range_hold;
		!$stable(heater_range_o) |-> $past(htr_wr_w) || $past(htr_wr_w, 2);
	endproperty
	a_range_hold: assert property (p_range_hold) else $error("range moved alone");
	property p_dac_span;
		$signed(dac_o[0]) <= cla_pkg::CODE_FS && $signed(dac_o[0]) >= -cla_pkg::CODE_FS
			&& $signed(dac_o[1]) <= cla_pkg::CODE_FS && $signed(dac_o[1]) >= -cla_pkg::CODE_FS;
	endproperty
	a_dac_span: assert property (p_dac_span) else $error("dac code out of span");
	c_overtemp: cover property (overtemp_o ##1 ctrl_o == '0);
endmodule
bind cla_limit_ao cla_limit_ao_asserts #(.TICK_CYC(TICK_CYC)) cla_limit_ao_asserts_inst (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i),
	.wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .ctrl_temp_i(ctrl_temp_i), .pid_i(pid_i),
	.reading_i(reading_i), .setpoint_o(setpoint_o), .overtemp_o(overtemp_o),
	.ctrl_o(ctrl_o), .heater_range_o(heater_range_o), .dac_o(dac_o)
);
`default_nettype wire

/* dv/cla_limit_ao_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cla_limit_ao_tb;
	// Short tick keeps slope tests brief
	localparam int TCK = 20;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic signed [31:0] temp = 32'h0;
	logic signed [1:0][15:0] pid = '0;
	logic signed [1:0][31:0] rdg = '0;
	logic [31:0] rdat;
	logic ack;
	logic signed [31:0] sp;
	logic ot;
	logic signed [1:0][15:0] ctl;
	logic [2:0] rng;
	logic signed [1:0][14:0] dac;
	logic [31:0] q;
	int errors = 0;
	int n_compared = 0;
	int cyc_n = 0;
	int n;
	logic [31:0] mcfg [6] = '{32'h3, 32'h3, 32'h7, 32'h7, 32'h7, 32'h4};
	logic [31:0] mman [6] = '{32'h1388, 32'hFFFFEC78, 32'hFFFFEC78, 32'hFFFFD8F0, 32'h2710,
		32'hFFFFEC78};
	logic [31:0] mexp [6] = '{32'hFA0, 32'h0, 32'hFFFFF060, 32'hFFFFE0C0, 32'h1F40, 32'h0};

	cla_limit_ao #(.TICK_CYC(TCK)) cla_limit_ao_inst (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF), .wb_stb_i(stb), .wb_cyc_i(cyc),
		.wb_ack_o(ack), .ctrl_temp_i(temp), .pid_i(pid), .reading_i(rdg), .setpoint_o(sp),
		.overtemp_o(ot), .ctrl_o(ctl), .heater_range_o(rng), .dac_o(dac)
	);

	always #5 clk_i = ~clk_i;

	task automatic stop_test();
		if (errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Run is a few hundred cycles at most
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 8000) begin
			errors++;
			stop_test();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Waits for ack; only the cycle ceiling ends a hang
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		check(nm, q, e);
	endtask

	task automatic cdac(input int c, input logic [31:0] e);
		repeat (3) @(posedge clk_i);
		check("dac", {{17{dac[c][14]}}, dac[c]}, e);
	endtask

	// Counts edges until loop 1 output leaves old
	task automatic wchg(input logic [15:0] old);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ctl[0] === old && n < 200);
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("outs", {2'b00, dac}, 32'h0);
		rd("glim", cla_pkg::A_GLIM, 32'hB98C);
		rd("slope", cla_pkg::A_SLOPE, 32'h0);
		rd("htr", cla_pkg::A_HTR, 32'h500);
		rd("cfg0", 8'h20, 32'h0);
		rd("cfg1", 8'h30, 32'h0);
		wr(cla_pkg::A_SP, 32'hC350);
		rd("sp", cla_pkg::A_SP, 32'hB98C);
		check("sp out", sp, 32'hB98C);
		rd("stat", cla_pkg::A_STAT, 32'h4);
		wr(cla_pkg::A_CLIM, 32'h80009C40);
		wr(cla_pkg::A_SP, 32'hAFC8);
		rd("sp curve", cla_pkg::A_SP, 32'h9C40);
		wr(cla_pkg::A_CLIM, 32'h9C40);
		wr(cla_pkg::A_SP, 32'hAFC8);
		rd("sp nocurve", cla_pkg::A_SP, 32'hAFC8);
		wr(cla_pkg::A_CTRL, 32'h1);
		wr(cla_pkg::A_SP, 32'h7530);
		rd("sp degc", cla_pkg::A_SP, 32'h4ED9);
		wr(cla_pkg::A_CTRL, 32'h2);
		wr(cla_pkg::A_SP, 32'h15F90);
		rd("sp sens", cla_pkg::A_SP, 32'h15F90);
		wr(8'hFC, 32'hFFFFFFFF);
		rd("unmapped", 8'hFC, 32'h0);
		temp <= 32'hBB80;
		repeat (2) @(posedge clk_i);
		check("ot", {31'h0, ot}, 32'h1);
		rd("stat ot", cla_pkg::A_STAT, 32'h1);
		temp <= 32'hB98C;
		repeat (2) @(posedge clk_i);
		check("ot edge", {31'h0, ot}, 32'h0);
		wr(cla_pkg::A_HTR, 32'h505);
		rd("htr5", cla_pkg::A_HTR, 32'h505);
		check("rng", {29'h0, rng}, 32'h5);
		wr(cla_pkg::A_HTR, 32'h303);
		wr(cla_pkg::A_HTR, 32'h603);
		wr(cla_pkg::A_HTR, 32'h304);
		rd("htr ref", cla_pkg::A_HTR, 32'h303);
		check("rng ref", {29'h0, rng}, 32'h3);
		rd("stat rng", cla_pkg::A_STAT, 32'h2);
		wr(cla_pkg::A_SLOPE, 32'h3E9);
		rd("slope hi", cla_pkg::A_SLOPE, 32'h0);
		wr(cla_pkg::A_SLOPE, 32'h3E8);
		rd("slope max", cla_pkg::A_SLOPE, 32'h3E8);
		wr(cla_pkg::A_SLOPE, 32'h64);
		pid <= {16'h09C4, 16'h03E8};
		wr(cla_pkg::A_CTRL, 32'hC);
		wchg(16'h0);
		check("ctl0 step", ctl[0], 32'h64);
		check("ctl1 step", ctl[1], 32'h64);
		wchg(16'h64);
		check("ctl0 step2", ctl[0], 32'hC8);
		check("tick", n, TCK);
		wr(cla_pkg::A_SLOPE, 32'h0);
		repeat (TCK + 2) @(posedge clk_i);
		check("ctl free", ctl, 32'h09C403E8);
		wr(cla_pkg::A_SLOPE, 32'h320000);
		pid[0] <= 16'h0;
		wchg(16'h3E8);
		check("ctl fall", ctl[0], 32'h3B6);
		wr(8'h30, 32'h2);
		cdac(1, 32'h7D0);
		wr(8'h20, 32'h2);
		rd("cfg0 loop", 8'h20, 32'h0);
		temp <= 32'hBB80;
		repeat (2) @(posedge clk_i);
		check("ctl off", ctl, 32'h0);
		temp <= 32'h0;
		wr(cla_pkg::A_SLOPE, 32'h0);
		pid[1] <= 16'hF63C;
		repeat (TCK + 2) @(posedge clk_i);
		cdac(1, 32'h0);
		wr(8'h30, 32'h6);
		cdac(1, 32'hFFFFF830);
		for (int i = 0; i < 6; i++) begin
			wr(8'h20, mcfg[i]);
			wr(8'h24, mman[i]);
			cdac(0, mexp[i]);
		end
		wr(8'h30, 32'h1);
		rdg[1] <= 32'h1F4;
		cdac(1, 32'hFA0);
		wr(8'h30, 32'h5);
		cdac(1, 32'h0);
		rdg[1] <= 32'h5DC;
		cdac(1, 32'h1F40);
		rdg[1] <= 32'hFFFFFE0C;
		cdac(1, 32'hFFFFE0C0);
		wr(8'h30, 32'h1);
		cdac(1, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
